//--- design/flash_seq_defs.vh
// Register offsets, field positions, command codes and timing counts of the flash sequencer
`ifndef FLASH_SEQ_DEFS_VH
`define FLASH_SEQ_DEFS_VH

// APB byte addresses of the sequencer registers
`define OFS_CLKDIV 12'h000
`define OFS_STATUS 12'h004
`define OFS_CMD 12'h008
`define OFS_ADDR 12'h00C
`define OFS_DATA 12'h010
`define OFS_WRITE_ARRAY 12'h014

// Status register fields
`define ST_CBEF 7
`define ST_CCF 6
`define ST_PVIOL 5
`define ST_ACCERR 4

// Divider register: bits 6:0 are the divide value, bit 7 shows it was loaded
`define DIV_LOADED 7

// Command codes
`define CMD_BLANK 8'h05
`define CMD_BYTE_PROG 8'h20
`define CMD_BURST_PROG 8'h25
`define CMD_PAGE_ERASE 8'h40
`define CMD_MASS_ERASE 8'h41

// Operation lengths in flash clock cycles
`define T_BYTE_PROG 15'h0009
`define T_BURST_PROG 15'h0004
`define T_PAGE_ERASE 15'h0FA0
`define T_MASS_ERASE 15'h4E20
`define T_BLANK 15'h0004

// Page of 512 bytes: the low 9 address bits select a byte within it
`define PAGE_BITS 9
`define ADDR_W 16

`endif

//--- design/flash_clk_div.v
// Divider that makes the one-cycle flash operation clock enable
`timescale 1ns/100ps
module flash_clk_div (
	// Clock and reset
	input wire clk_i,
	input wire sys_rst_i,
	// Control
	input wire run_i,
	input wire [6:0] div_i,
	// Enable out
	output reg tick_o
);
	reg [6:0] cnt_reg;

	// Period is div_i + 1 bus cycles; held at zero while idle so each run starts aligned
	always @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			cnt_reg <= 7'h00;
			tick_o <= 1'b0;
		end else if (!run_i) begin
			cnt_reg <= 7'h00;
			tick_o <= 1'b0;
		end else if (cnt_reg == div_i) begin
			cnt_reg <= 7'h00;
			tick_o <= 1'b1;
		end else begin
			cnt_reg <= cnt_reg + 7'h01;
			tick_o <= 1'b0;
		end
	end
endmodule

//--- design/flash_program_erase_sequencer.v
// Flash program, erase and blank-check command sequencer with an APB register port
//
// Contract
// - Byte program 9, burst 4, page erase 4000, mass erase 20000 flash clocks.
// - Each sequence starts with an array write; address and data are latched.
// - Page erase takes any page address; data ignored for erase and blank check.
// - Erase granularity is one whole 512-byte page.
// - Codes: blank check 0x05, byte program 0x20, burst program 0x25.
// - Codes: page erase 0x40, mass erase 0x41; all others invalid.
// - Command register write captures the code into the command buffer.
// - Writing one to buffer-empty flag launches the command and clears the flag.
// - Writing zero to buffer-empty flag mid-sequence aborts and sets access error.
// - Any departure from write, command, launch order is rejected.
// - Command-complete flag shows when the launched command has finished.
`timescale 1ns/100ps
`include "flash_seq_defs.vh"
module flash_program_erase_sequencer (
	// Clock and reset
	input wire clk_i,
	input wire sys_rst_i,
	// APB slave
	input wire psel_i,
	input wire penable_i,
	input wire pwrite_i,
	input wire [11:0] paddr_i,
	input wire [31:0] pwdata_i,
	output reg [31:0] prdata_o,
	output reg pready_o,
	output reg pslverr_o,
	// Flash array side
	output reg array_busy_o,
	output reg [7:0] array_cmd_o,
	output reg [`ADDR_W-1:0] array_addr_o,
	output reg [7:0] array_data_o,
	output reg array_done_o
);
	localparam S_IDLE = 4'b0001;
	localparam S_ADDR = 4'b0010;
	localparam S_CMD = 4'b0100;
	localparam S_RUN = 4'b1000;

	reg [3:0] state_reg;
	reg [3:0] state_next;
	reg [7:0] div_reg;
	reg cbef_reg;
	reg ccf_reg;
	reg accerr_reg;
	reg pviol_reg;
	reg [7:0] cmd_reg;
	reg [`ADDR_W-1:0] addr_reg;
	reg [7:0] data_reg;
	reg [14:0] cnt_reg;
	reg [7:0] div_next;
	reg cbef_next;
	reg ccf_next;
	reg accerr_next;
	reg pviol_next;
	reg [7:0] cmd_next;
	reg [`ADDR_W-1:0] addr_next;
	reg [7:0] data_next;
	reg [14:0] cnt_next;
	reg [7:0] array_cmd_next;
	reg [`ADDR_W-1:0] array_addr_next;
	reg [7:0] array_data_next;
	reg [31:0] rdata_next;
	wire tick;
	wire wr_en;
	wire rd_en;
	wire div_ok;
	wire fire;

	assign wr_en = psel_i && penable_i && pwrite_i;
	assign rd_en = psel_i && penable_i && !pwrite_i;
	assign div_ok = div_reg[`DIV_LOADED];

	function cmd_valid;
		input [7:0] c;
		begin
			cmd_valid = (c == `CMD_BLANK) || (c == `CMD_BYTE_PROG) ||
				(c == `CMD_BURST_PROG) || (c == `CMD_PAGE_ERASE) ||
				(c == `CMD_MASS_ERASE);
		end
	endfunction

	function [14:0] cmd_len;
		input [7:0] c;
		begin
			case (c)
				`CMD_BYTE_PROG: cmd_len = `T_BYTE_PROG;
				`CMD_BURST_PROG: cmd_len = `T_BURST_PROG;
				`CMD_PAGE_ERASE: cmd_len = `T_PAGE_ERASE;
				`CMD_MASS_ERASE: cmd_len = `T_MASS_ERASE;
				default: cmd_len = `T_BLANK;
			endcase
		end
	endfunction

	// Launch accepted only with a complete sequence and no pending error
	assign fire = wr_en && (paddr_i == `OFS_STATUS) && pwdata_i[`ST_CBEF] &&
		(state_reg == S_CMD) && !accerr_reg && div_ok;

	flash_clk_div u_div (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.run_i(state_reg == S_RUN),
		.div_i(div_reg[6:0]),
		.tick_o(tick)
	);

	always @* begin
		state_next = state_reg;
		case (state_reg)
			S_IDLE: begin
				if (wr_en && paddr_i == `OFS_WRITE_ARRAY && !accerr_reg && div_ok)
					state_next = S_ADDR;
			end
			S_ADDR: begin
				if (wr_en && paddr_i == `OFS_CMD) begin
					if (cmd_valid(pwdata_i[7:0]))
						state_next = S_CMD;
					else
						state_next = S_IDLE;
				end else if (wr_en && paddr_i == `OFS_STATUS && !pwdata_i[`ST_CBEF]) begin
					state_next = S_IDLE;
				end else if (wr_en && paddr_i == `OFS_WRITE_ARRAY) begin
					state_next = S_IDLE;
				end
			end
			S_CMD: begin
				if (fire)
					state_next = S_RUN;
				else if (wr_en && (paddr_i == `OFS_STATUS || paddr_i == `OFS_CMD ||
					paddr_i == `OFS_WRITE_ARRAY))
					state_next = S_IDLE;
			end
			S_RUN: begin
				if (tick && cnt_reg == 15'h0001)
					state_next = S_IDLE;
			end
			default: state_next = S_IDLE;
		endcase
	end

	// Next values of the settings and of the latched sequence
	always @* begin
		div_next = div_reg;
		addr_next = addr_reg;
		data_next = data_reg;
		cmd_next = cmd_reg;
		// Divider is locked while a command runs, so timing cannot shift mid-operation
		if (wr_en && paddr_i == `OFS_CLKDIV && state_reg != S_RUN)
			div_next = {1'b1, pwdata_i[6:0]};
		if (state_reg == S_IDLE && state_next == S_ADDR) begin
			addr_next = pwdata_i[`ADDR_W+7:8];
			data_next = pwdata_i[7:0];
		end
		if (state_reg == S_ADDR && state_next == S_CMD)
			cmd_next = pwdata_i[7:0];
	end

	// Next values of the status flags and the operation counter
	always @* begin
		cbef_next = cbef_reg;
		ccf_next = ccf_reg;
		cnt_next = cnt_reg;
		accerr_next = accerr_reg;
		pviol_next = pviol_reg;
		if (fire) begin
			cbef_next = 1'b0;
			ccf_next = 1'b0;
			cnt_next = cmd_len(cmd_reg);
		end else if (state_reg == S_RUN && tick) begin
			cnt_next = cnt_reg - 15'h0001;
			if (cnt_reg == 15'h0001) begin
				ccf_next = 1'b1;
				cbef_next = 1'b1;
			end
		end
		// Error set wins over a same-cycle clear
		if ((state_reg == S_ADDR || state_reg == S_CMD) && state_next == S_IDLE)
			accerr_next = 1'b1;
		else if (state_reg == S_IDLE && wr_en && paddr_i == `OFS_WRITE_ARRAY &&
			!div_ok)
			accerr_next = 1'b1;
		else if (state_reg == S_IDLE && wr_en && paddr_i == `OFS_CMD)
			accerr_next = 1'b1;
		else if (state_reg == S_RUN && wr_en && paddr_i != `OFS_CLKDIV &&
			paddr_i != `OFS_STATUS)
			accerr_next = 1'b1;
		else if (wr_en && paddr_i == `OFS_STATUS && pwdata_i[`ST_ACCERR])
			accerr_next = 1'b0;
		// Reserved flag is never set here; it stays write-one-to-clear for software
		if (wr_en && paddr_i == `OFS_STATUS && pwdata_i[`ST_PVIOL])
			pviol_next = 1'b0;
	end

	always @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			state_reg <= S_IDLE;
			div_reg <= 8'h00;
			cbef_reg <= 1'b1;
			ccf_reg <= 1'b1;
			accerr_reg <= 1'b0;
			pviol_reg <= 1'b0;
			cmd_reg <= 8'h00;
			addr_reg <= 16'h0000;
			data_reg <= 8'h00;
			cnt_reg <= 15'h0000;
		end else begin
			state_reg <= state_next;
			div_reg <= div_next;
			cbef_reg <= cbef_next;
			ccf_reg <= ccf_next;
			accerr_reg <= accerr_next;
			pviol_reg <= pviol_next;
			cmd_reg <= cmd_next;
			addr_reg <= addr_next;
			data_reg <= data_next;
			cnt_reg <= cnt_next;
		end
	end

	// Array side outputs, page erase address forced to page base
	always @* begin
		array_cmd_next = array_cmd_o;
		array_addr_next = array_addr_o;
		array_data_next = array_data_o;
		if (fire) begin
			array_cmd_next = cmd_reg;
			if (cmd_reg == `CMD_PAGE_ERASE)
				array_addr_next = {addr_reg[`ADDR_W-1:`PAGE_BITS],
					{`PAGE_BITS{1'b0}}};
			else
				array_addr_next = addr_reg;
			if (cmd_reg == `CMD_BYTE_PROG || cmd_reg == `CMD_BURST_PROG)
				array_data_next = data_reg;
			else
				array_data_next = 8'hFF;
		end
	end

	always @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			array_busy_o <= 1'b0;
			array_cmd_o <= 8'h00;
			array_addr_o <= 16'h0000;
			array_data_o <= 8'h00;
			array_done_o <= 1'b0;
		end else begin
			array_busy_o <= (state_next == S_RUN);
			array_done_o <= (state_reg == S_RUN) && (state_next == S_IDLE);
			array_cmd_o <= array_cmd_next;
			array_addr_o <= array_addr_next;
			array_data_o <= array_data_next;
		end
	end

	// Register map decode; anything else answers with a bus error
	function addr_mapped;
		input [11:0] a;
		begin
			addr_mapped = (a == `OFS_CLKDIV) || (a == `OFS_STATUS) || (a == `OFS_CMD) ||
				(a == `OFS_ADDR) || (a == `OFS_DATA) || (a == `OFS_WRITE_ARRAY);
		end
	endfunction

	// Read data is picked in the setup phase and stands through the access phase
	always @* begin
		case (paddr_i)
			`OFS_CLKDIV: rdata_next = {24'h000000, div_reg};
			`OFS_STATUS: rdata_next = {24'h000000, cbef_reg, ccf_reg, pviol_reg,
				accerr_reg, 4'h0};
			`OFS_CMD: rdata_next = {24'h000000, cmd_reg};
			`OFS_ADDR: rdata_next = {16'h0000, addr_reg};
			`OFS_DATA: rdata_next = {24'h000000, data_reg};
			default: rdata_next = 32'h00000000;
		endcase
	end

	// APB: zero-wait answer, error on unmapped address
	always @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			prdata_o <= 32'h00000000;
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
		end else begin
			pready_o <= psel_i && !penable_i;
			pslverr_o <= psel_i && !penable_i && !addr_mapped(paddr_i);
			prdata_o <= (psel_i && !penable_i) ? rdata_next : 32'h00000000;
		end
	end
	// rd_en is kept for clarity of the access phase
	wire unused_rd = rd_en;
endmodule

//--- tb/flash_array_model.sv
// Flash array stand-in: flags a byte programmed twice without an erase between
`timescale 1ns/100ps
`include "flash_seq_defs.vh"
module flash_array_model (
	// Clock
	input wire clk_i,
	// Finished command from the sequencer
	input wire done_i,
	input wire [7:0] cmd_i,
	input wire [15:0] addr_i,
	// Misuse flag
	output reg reprog_o
);
	reg used [0:65535];
	integer k;
	integer j;
	initial begin
		reprog_o = 1'b0;
		for (k = 0; k < 65536; k = k + 1)
			used[k] = 1'b0;
	end
	always @(posedge clk_i) begin
		if (done_i && (cmd_i == 8'h20 || cmd_i == 8'h25)) begin
			if (used[addr_i])
				reprog_o <= 1'b1;
			used[addr_i] <= 1'b1;
		end
		// Only an erase walks the whole array, so idle cycles stay cheap
		if (done_i && (cmd_i == 8'h41 || cmd_i == 8'h40))
			for (j = 0; j < 65536; j = j + 1)
				if (cmd_i == 8'h41 || j[15:9] == addr_i[15:9])
					used[j] <= 1'b0;
	end
endmodule

//--- tb/fpes_sva.sv
// Port checker for the flash sequencer
`timescale 1ns/100ps
`include "flash_seq_defs.vh"
module fpes_sva (
	// Clock, reset and bus
	input wire clk_i,
	input wire sys_rst_i,
	input wire psel_i,
	input wire penable_i,
	input wire pwrite_i,
	input wire [11:0] paddr_i,
	input wire [31:0] pwdata_i,
	input wire pready_o,
	input wire pslverr_o,
	// Array side
	input wire array_busy_o,
	input wire [7:0] array_cmd_o,
	input wire [`ADDR_W-1:0] array_addr_o,
	input wire array_done_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	wire go = psel_i && penable_i && pwrite_i && paddr_i == `OFS_STATUS && pwdata_i[7];
	chk_ready_setup: assert property (psel_i && !penable_i |=> pready_o)
		else $error("pready late");
	chk_err_ready: assert property (pslverr_o |-> pready_o)
		else $error("pslverr without pready");
	chk_done_pulse: assert property (array_done_o |=> !array_done_o)
		else $error("done too long");
	chk_done_idle: assert property (array_done_o |-> ##[0:1] !array_busy_o)
		else $error("busy after done");
	chk_busy_cause: assert property ($rose(array_busy_o) |-> $past(go) || $past(go, 2))
		else $error("start without launch");
	chk_cmd_code: assert property ($rose(array_busy_o) |->
		array_cmd_o inside {8'h05, 8'h20, 8'h25, 8'h40, 8'h41})
		else $error("bad code run");
	chk_args_hold: assert property (array_busy_o && $past(array_busy_o) |->
		$stable(array_cmd_o) && $stable(array_addr_o))
		else $error("args moved");
	chk_page_whole: assert property (array_busy_o && array_cmd_o == 8'h40 |->
		array_addr_o[8:0] == 9'h000)
		else $error("page not whole");
	cover property ($rose(array_busy_o) && array_cmd_o == 8'h41);
	cover property (pslverr_o);
	cover property (array_done_o);
endmodule
bind flash_program_erase_sequencer fpes_sva fpes_sva_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
	.psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
	.pwdata_i(pwdata_i), .pready_o(pready_o), .pslverr_o(pslverr_o),
	.array_busy_o(array_busy_o), .array_cmd_o(array_cmd_o), .array_addr_o(array_addr_o),
	.array_done_o(array_done_o));

//--- tb/flash_program_erase_sequencer_test.sv
// Self-checking bench for the flash sequencer
`timescale 1ns/100ps
`include "flash_seq_defs.vh"
module flash_program_erase_sequencer_test;
	reg clk_i = 1'b0;
	reg sys_rst_i = 1'b1;
	reg psel_i = 1'b0;
	reg penable_i = 1'b0;
	reg pwrite_i = 1'b0;
	reg [11:0] paddr_i = 12'h000;
	reg [31:0] pwdata_i = 32'h0000_0000;
	wire [31:0] prdata_o;
	wire pready_o, pslverr_o, array_busy_o, array_done_o, reprog;
	wire [7:0] array_cmd_o, array_data_o;
	wire [15:0] array_addr_o;
	integer n_errors = 0, samples_checked = 0, cyc = 0, i, n;
	reg [31:0] rd;
	reg er;
	reg [70:0] rows [0:4];
	reg [7:0] c, d, ed;
	reg [15:0] a, ea;
	reg [14:0] tn;
	flash_program_erase_sequencer flash_program_erase_sequencer_i (.clk_i(clk_i),
		.sys_rst_i(sys_rst_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
		.paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
		.pslverr_o(pslverr_o), .array_busy_o(array_busy_o), .array_cmd_o(array_cmd_o),
		.array_addr_o(array_addr_o), .array_data_o(array_data_o), .array_done_o(array_done_o));
	flash_array_model flash_array_model_i (.clk_i(clk_i), .done_i(array_done_o),
		.cmd_i(array_cmd_o), .addr_i(array_addr_o), .reprog_o(reprog));
	always #4 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			n_errors = n_errors + 1;
			end_of_test;
		end
	end
	task end_of_test;
		begin
			$display("checks %0d errors %0d", samples_checked, n_errors);
			if (n_errors == 0 && samples_checked > 0)
				$display("TB: PASS");
			else
				$display("TB: FAIL");
			$finish;
		end
	endtask
	task check(input string nm, input [31:0] e, input [31:0] g);
		begin
			samples_checked = samples_checked + 1;
			if (g !== e) begin
				n_errors = n_errors + 1;
				$display("[ERR] %s expected %h seen %h", nm, e, g);
			end
		end
	endtask
	// Starts and ends just after a rising edge; an idle edge follows each transfer
	task apb(input w, input [11:0] ad, input [31:0] dt);
		begin
			psel_i <= 1'b1;
			pwrite_i <= w;
			paddr_i <= ad;
			pwdata_i <= dt;
			@(posedge clk_i);
			penable_i <= 1'b1;
			@(posedge clk_i);
			while (pready_o !== 1'b1)
				@(posedge clk_i);
			rd = prdata_o;
			er = pslverr_o;
			psel_i <= 1'b0;
			penable_i <= 1'b0;
			@(posedge clk_i);
		end
	endtask
	task run(input [7:0] cc, input [15:0] aa, input [7:0] dd);
		begin
			apb(1'b1, `OFS_WRITE_ARRAY, {8'h00, aa, dd});
			apb(1'b1, `OFS_CMD, {24'h000000, cc});
			apb(1'b1, `OFS_STATUS, 32'h0000_0080);
		end
	endtask
	// Counts busy cycles; a slack of two covers start and end overhead
	task wait_done(input integer e);
		begin
			n = 0;
			while (array_done_o !== 1'b1) begin
				@(posedge clk_i);
				n = n + (array_busy_o === 1'b1);
			end
			check("busy cycles", e, (n > e && n <= e + 2) ? e : n);
		end
	endtask
	task st(input [31:0] e);
		begin
			apb(1'b0, `OFS_STATUS, 32'h0000_0000);
			check("status", e, rd);
		end
	endtask
	initial begin
		rows[0] = {8'h20, 16'h1234, 8'h5A, 15'h0009, 16'h1234, 8'h5A};
		rows[1] = {8'h25, 16'h1235, 8'hA5, 15'h0004, 16'h1235, 8'hA5};
		rows[2] = {8'h05, 16'h2000, 8'h00, 15'h0004, 16'h2000, 8'h00};
		rows[3] = {8'h40, 16'h1377, 8'h00, 15'h0FA0, 16'h1200, 8'hFF};
		rows[4] = {8'h41, 16'h0010, 8'h12, 15'h4E20, 16'h0010, 8'hFF};
		repeat (5) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		@(posedge clk_i);
		st(32'h0000_00C0);
		apb(1'b0, 12'h018, 32'h0000_0000);
		check("unmapped", 1, er);
		apb(1'b1, `OFS_CLKDIV, 32'h0000_0000);
		for (i = 0; i < 5; i = i + 1) begin
			{c, a, d, tn, ea, ed} = rows[i];
			run(c, a, d);
			wait_done(tn);
			check("cmd", c, array_cmd_o);
			check("addr", ea, array_addr_o);
			if (c != 8'h05)
				check("data", ed, array_data_o);
			st(32'h0000_00C0);
		end
		apb(1'b1, `OFS_CLKDIV, 32'h0000_0003);
		run(8'h20, 16'h0400, 8'h11);
		st(32'h0000_0000);
		// Nine ticks of four bus cycles, less the three cycles the status read used
		wait_done(9 * 4 - 3);
		run(8'h25, 16'h0401, 8'h22);
		wait_done(16);
		// Abort, command without array write, then an undefined code
		for (i = 0; i < 3; i = i + 1) begin
			if (i != 1)
				apb(1'b1, `OFS_WRITE_ARRAY, 32'h0005_0033);
			apb(1'b1, i == 0 ? `OFS_STATUS : `OFS_CMD, i == 2 ? 32'h33 : i * 32'h20);
			st(32'h0000_00D0);
			apb(1'b1, `OFS_STATUS, 32'h0000_0010);
			st(32'h0000_00C0);
		end
		// Reset in mid-run: flags come back, divider unloaded, array write refused
		run(8'h40, 16'h0200, 8'h00);
		sys_rst_i <= 1'b1;
		@(posedge clk_i);
		check("busy in reset", 0, array_busy_o);
		sys_rst_i <= 1'b0;
		@(posedge clk_i);
		st(32'h0000_00C0);
		apb(1'b0, `OFS_CLKDIV, 32'h0000_0000);
		check("divider", 0, rd);
		apb(1'b1, `OFS_WRITE_ARRAY, 32'h0005_0033);
		st(32'h0000_00D0);
		apb(1'b1, `OFS_STATUS, 32'h0000_0010);
		st(32'h0000_00C0);
		check("reprogram", 0, reprog);
		end_of_test;
	end
endmodule
